//--- logic/bdsc_pkg.sv
package bdsc_pkg;

  localparam int unsigned CTRL_W   = 8;
  localparam int unsigned MATCH_W  = 16;

  // field positions of debug_status_control
  localparam int unsigned BIT_PERMIT   = 7;
  localparam int unsigned BIT_ACTIVE   = 6;
  localparam int unsigned BIT_BKPT_EN  = 5;
  localparam int unsigned BIT_FTS      = 4;
  localparam int unsigned BIT_CLK_SEL  = 3;
  localparam int unsigned BIT_WS       = 2;
  localparam int unsigned BIT_WSF      = 1;
  localparam int unsigned BIT_DVF      = 0;

  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [15:0] MATCH_RST    = 16'h0000;

  typedef enum logic [2:0] {
    CMD_NONE       = 3'h0,
    CMD_READ_CTRL  = 3'h1,
    CMD_WRITE_CTRL = 3'h2,
    CMD_MATCH_RD   = 3'h3,
    CMD_MATCH_WR   = 3'h4,
    CMD_FORCE_BGND = 3'h5,
    CMD_MEM_ACCESS = 3'h6,
    CMD_GO         = 3'h7
  } bdsc_cmd_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'h0,
    ST_WAIT   = 2'h1,
    ST_ACTIVE = 2'h2
  } bdsc_state_t;

  typedef struct packed {
    logic       valid;
    bdsc_cmd_t  cmd;
    logic [15:0] data;
  } bdsc_req_t;

  typedef struct packed {
    logic        done;
    logic        fail;
    logic [15:0] data;
  } bdsc_rsp_t;

  typedef struct packed {
    logic        boundary;
    logic        queue_end;
    logic        fetch;
    logic        wait_stop;
    logic [15:0] addr;
  } bdsc_cpu_t;

endpackage : bdsc_pkg

//--- logic/bdsc_match.sv
`timescale 1ns/10ps
module bdsc_match
  import bdsc_pkg::*;
#(
  parameter int unsigned AW = 16
) (
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [AW-1:0] match_i,
  input  wire logic          enable_i,
  output logic               hit_o
);
  assign hit_o = enable_i && (addr_i == match_i);
endmodule : bdsc_match

//--- logic/bdsc_tagq.sv
`timescale 1ns/10ps
module bdsc_tagq
  import bdsc_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic ce_i,
  input  wire logic tag_set_i,
  input  wire logic queue_end_i,
  input  wire logic flush_i,
  output logic      tag_hit_o
);
  // remembers one tagged opcode until it retires or is flushed
  logic pend_r;
  logic pend_nxt;
  always_comb begin
    pend_nxt = pend_r;
    if (flush_i) begin
      pend_nxt = 1'b0;
    end else if (tag_set_i) begin
      pend_nxt = 1'b1;
    end else if (queue_end_i) begin
      pend_nxt = 1'b0;
    end
  end
  assign tag_hit_o = pend_r && queue_end_i;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_r <= 1'b0;
    end else if (ce_i) begin
      pend_r <= pend_nxt;
    end
  end
endmodule : bdsc_tagq

//--- logic/bdsc_top.sv
`timescale 1ns/10ps
module bdsc_top
  import bdsc_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  input  wire bdsc_pkg::bdsc_req_t req_i,
  input  wire bdsc_pkg::bdsc_cpu_t cpu_i,
  output bdsc_pkg::bdsc_rsp_t    rsp_o,
  output logic                   enter_bgnd_o,
  output logic                   swi_req_o,
  output logic                   comm_clk_sel_o,
  output logic                   bgnd_active_o
);
  import bdsc_pkg::*;

  typedef struct packed {
    bdsc_state_t state;
    logic        permit;
    logic        bkpt_en;
    logic        force_tag_select;
    logic        clk_sel;
    logic        ws_from_wait;
    logic        wait_stop_failure;
    logic        force_pend;
    logic [15:0] match;
    bdsc_rsp_t   rsp;
    logic        enter;
    logic        software_interrupt_instr;
    logic        active;
  } bdsc_st_t;

  bdsc_st_t st_r;
  bdsc_st_t st_nxt;
  logic     hit;
  logic     tag_hit;
  logic     in_bgnd;
  logic [7:0] ctrl_rd;
  // one strobe per serial command
  logic        cmd_rd_ctrl;
  logic        cmd_wr_ctrl;
  logic        cmd_rd_match;
  logic        cmd_wr_match;
  logic        cmd_force;
  logic        cmd_mem;
  logic        cmd_go;
  logic        cmd_bad;
  logic        force_ok;
  logic        go_ok;
  logic        mem_blocked;
  logic        force_hit;
  logic        force_brk;
  logic        tag_brk;
  logic        brk_req;
  logic        permit_nxt;
  logic        bkpt_en_nxt;
  logic        fts_nxt;
  logic        clk_sel_nxt;
  logic        ws_hist_nxt;
  logic        wsf_nxt;
  logic        pend_nxt;
  logic        rsp_fail;
  logic [15:0] rsp_data;
  bdsc_state_t track_state;

  assign in_bgnd = (st_r.state == ST_ACTIVE);

  bdsc_match #(
    .AW (MATCH_W)
  ) u_match (
    .addr_i   (cpu_i.addr),
    .match_i  (st_r.match),
    .enable_i (st_r.bkpt_en && !in_bgnd),
    .hit_o    (hit)
  );

  bdsc_tagq u_tagq (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .tag_set_i   (hit && !st_r.force_tag_select && cpu_i.fetch),
    .queue_end_i (cpu_i.queue_end),
    .flush_i     (in_bgnd),
    .tag_hit_o   (tag_hit)
  );

  always_comb begin
    ctrl_rd                = CTRL_RST;
    ctrl_rd[BIT_PERMIT]    = st_r.permit;
    ctrl_rd[BIT_ACTIVE]    = in_bgnd;
    ctrl_rd[BIT_BKPT_EN]   = st_r.bkpt_en;
    ctrl_rd[BIT_FTS]       = st_r.force_tag_select;
    ctrl_rd[BIT_CLK_SEL]   = st_r.clk_sel;
    ctrl_rd[BIT_WS]        = (st_r.state == ST_WAIT) || st_r.ws_from_wait;
    ctrl_rd[BIT_WSF]       = st_r.wait_stop_failure;
    ctrl_rd[BIT_DVF]       = 1'b0;
  end

  // serial commands are the only register path; an unknown code is refused
  always_comb begin
    cmd_rd_ctrl  = 1'b0;
    cmd_wr_ctrl  = 1'b0;
    cmd_rd_match = 1'b0;
    cmd_wr_match = 1'b0;
    cmd_force    = 1'b0;
    cmd_mem      = 1'b0;
    cmd_go       = 1'b0;
    cmd_bad      = 1'b0;
    if (req_i.valid) begin
      case (req_i.cmd)
        CMD_READ_CTRL: begin
          cmd_rd_ctrl = 1'b1;
        end
        CMD_WRITE_CTRL: begin
          cmd_wr_ctrl = 1'b1;
        end
        CMD_MATCH_RD: begin
          cmd_rd_match = 1'b1;
        end
        CMD_MATCH_WR: begin
          cmd_wr_match = 1'b1;
        end
        CMD_FORCE_BGND: begin
          cmd_force = 1'b1;
        end
        CMD_MEM_ACCESS: begin
          cmd_mem = 1'b1;
        end
        CMD_GO: begin
          cmd_go = 1'b1;
        end
        default: begin
          cmd_bad = 1'b1;
        end
      endcase
    end
  end

  // follow cpu wait/stop while user code runs; background ignores it
  always_comb begin
    track_state = st_r.state;
    case (st_r.state)
      ST_RUN: begin
        if (cpu_i.wait_stop) begin
          track_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!cpu_i.wait_stop) begin
          track_state = ST_RUN;
        end
      end
      ST_ACTIVE: begin
        track_state = ST_ACTIVE;
      end
      default: begin
        track_state = ST_RUN;
      end
    endcase
  end

  // force requests wait for a boundary, tags for the queue end
  always_comb begin
    force_hit = hit && st_r.force_tag_select;
    force_brk = 1'b0;
    tag_brk   = 1'b0;
    if (!in_bgnd) begin
      force_brk = (st_r.force_pend || force_hit) && cpu_i.boundary;
      tag_brk   = tag_hit;
    end
    brk_req = force_brk || tag_brk;
  end

  // a memory access collides with wait/stop unless background owns the cpu
  assign mem_blocked = (st_r.state == ST_WAIT) || (cpu_i.wait_stop && !in_bgnd);
  assign force_ok    = cmd_force && st_r.permit && !in_bgnd;
  assign go_ok       = cmd_go && in_bgnd;

  // answer word for the command taken this cycle
  always_comb begin
    rsp_data = MATCH_RST;
    if (cmd_rd_ctrl) begin
      rsp_data = {8'h00, ctrl_rd};
    end else if (cmd_rd_match) begin
      rsp_data = st_r.match;
    end
  end

  // commands that are unknown or that the present state cannot serve
  always_comb begin
    rsp_fail = cmd_bad;
    if (cmd_force && !st_r.permit) begin
      rsp_fail = 1'b1;
    end
    if (cmd_mem && mem_blocked) begin
      rsp_fail = 1'b1;
    end
    if (cmd_go && !in_bgnd) begin
      rsp_fail = 1'b1;
    end
  end

  // control write: permit frozen in background, status bits never land
  always_comb begin
    permit_nxt  = st_r.permit;
    bkpt_en_nxt = st_r.bkpt_en;
    fts_nxt     = st_r.force_tag_select;
    clk_sel_nxt = st_r.clk_sel;
    if (cmd_wr_ctrl) begin
      if (!in_bgnd) begin
        permit_nxt = req_i.data[BIT_PERMIT];
      end
      bkpt_en_nxt = req_i.data[BIT_BKPT_EN];
      fts_nxt     = req_i.data[BIT_FTS];
      clk_sel_nxt = req_i.data[BIT_CLK_SEL];
    end
  end

  // wait/stop history: kept while a forced entry came from wait, until resume
  always_comb begin
    ws_hist_nxt = st_r.ws_from_wait;
    if (brk_req && st_r.permit) begin
      ws_hist_nxt = 1'b0;
    end
    if (force_ok) begin
      ws_hist_nxt = (st_r.state == ST_WAIT);
    end
    if (go_ok) begin
      ws_hist_nxt = 1'b0;
    end
  end

  // a force hit is held until an instruction boundary or a forced entry
  always_comb begin
    pend_nxt = st_r.force_pend;
    if (force_hit) begin
      pend_nxt = 1'b1;
    end
    if (force_brk) begin
      pend_nxt = 1'b0;
    end
    if (force_ok) begin
      pend_nxt = 1'b0;
    end
  end

  // failure flag follows the outcome of the latest memory access
  always_comb begin
    wsf_nxt = st_r.wait_stop_failure;
    if (cmd_mem) begin
      wsf_nxt = mem_blocked;
    end
  end

  always_comb begin
    st_nxt              = st_r;
    st_nxt.state        = track_state;
    st_nxt.permit       = permit_nxt;
    st_nxt.bkpt_en      = bkpt_en_nxt;
    st_nxt.force_tag_select          = fts_nxt;
    st_nxt.clk_sel      = clk_sel_nxt;
    st_nxt.ws_from_wait = ws_hist_nxt;
    st_nxt.wait_stop_failure          = wsf_nxt;
    st_nxt.force_pend   = pend_nxt;
    st_nxt.rsp.done     = req_i.valid;
    st_nxt.rsp.fail     = rsp_fail;
    st_nxt.enter        = 1'b0;
    st_nxt.software_interrupt_instr          = 1'b0;
    if (req_i.valid) begin
      st_nxt.rsp.data = rsp_data;
    end
    if (brk_req) begin
      if (st_r.permit) begin
        st_nxt.state = ST_ACTIVE;
        st_nxt.enter = 1'b1;
      end else begin
        st_nxt.software_interrupt_instr = 1'b1;
      end
    end
    if (cmd_wr_match) begin
      st_nxt.match = req_i.data;
    end
    if (force_ok) begin
      st_nxt.state = ST_ACTIVE;
      st_nxt.enter = 1'b1;
    end
    if (go_ok) begin
      st_nxt.state = ST_RUN;
    end
    // the active output is a register of its own
    st_nxt.active = (st_nxt.state == ST_ACTIVE);
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r.state        <= ST_RUN;
      st_r.permit       <= 1'b0;
      st_r.bkpt_en      <= 1'b0;
      st_r.force_tag_select          <= 1'b0;
      st_r.clk_sel      <= 1'b0;
      st_r.ws_from_wait <= 1'b0;
      st_r.wait_stop_failure          <= 1'b0;
      st_r.force_pend   <= 1'b0;
      st_r.match        <= MATCH_RST;
      st_r.rsp          <= '0;
      st_r.enter        <= 1'b0;
      st_r.software_interrupt_instr          <= 1'b0;
      st_r.active       <= 1'b0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign rsp_o          = st_r.rsp;
  assign enter_bgnd_o   = st_r.enter;
  assign swi_req_o      = st_r.software_interrupt_instr;
  assign comm_clk_sel_o = st_r.clk_sel;
  assign bgnd_active_o  = st_r.active;

endmodule : bdsc_top

//--- bench/bdsc_top_sva.sv
`timescale 1ns/10ps
module bdsc_top_sva
  import bdsc_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                rstn_i,
  input  wire logic                ce_i,
  input  wire bdsc_pkg::bdsc_req_t req_i,
  input  wire bdsc_pkg::bdsc_cpu_t cpu_i,
  input  wire bdsc_pkg::bdsc_rsp_t rsp_o,
  input  wire logic                enter_bgnd_o,
  input  wire logic                swi_req_o,
  input  wire logic                comm_clk_sel_o,
  input  wire logic                bgnd_active_o
);
  import bdsc_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic tk = ce_i && req_i.valid;
  a_answer_next: assert property (tk |=> rsp_o.done)
    else $error("no answer after request");
  a_read_zero: assert property (tk && req_i.cmd == CMD_READ_CTRL |=>
    rsp_o.data[15:8] == 8'h00 && !rsp_o.data[0]) else $error("unused bits not zero");
  a_go_refused: assert property (tk && req_i.cmd == CMD_GO && !bgnd_active_o |=>
    rsp_o.fail) else $error("go accepted while running");
  a_mem_refused: assert property (tk && req_i.cmd == CMD_MEM_ACCESS &&
    cpu_i.wait_stop && !bgnd_active_o |=> rsp_o.fail) else $error("access during wait ok");
  a_enter_active: assert property (enter_bgnd_o |-> bgnd_active_o)
    else $error("entry pulse without active");
  a_rise_enter: assert property ($rose(bgnd_active_o) |-> enter_bgnd_o)
    else $error("active without entry pulse");
  a_swi_excl: assert property (swi_req_o |-> !enter_bgnd_o && !bgnd_active_o)
    else $error("software interrupt with entry");
  a_active_kept: assert property (tk && req_i.cmd == CMD_WRITE_CTRL && bgnd_active_o
    |=> bgnd_active_o) else $error("control write left background");
  a_clk_stable: assert property (!tk [*2] |=> $stable(comm_clk_sel_o))
    else $error("clock select moved without write");
endmodule : bdsc_top_sva
bind bdsc_top bdsc_top_sva u_sva (.ref_clk_i, .rstn_i, .ce_i, .req_i, .cpu_i, .rsp_o,
  .enter_bgnd_o, .swi_req_o, .comm_clk_sel_o, .bgnd_active_o);

//--- bench/bdsc_host.sv
`timescale 1ns/10ps
module bdsc_host
  import bdsc_pkg::*;
(
  input  wire logic                ref_clk_i,
  output bdsc_pkg::bdsc_req_t      req_o,
  input  wire bdsc_pkg::bdsc_rsp_t rsp_i
);
  import bdsc_pkg::*;
  bdsc_rsp_t got;
  initial req_o = '0;
  task automatic send(input bdsc_cmd_t c, input logic [15:0] d);
    @(negedge ref_clk_i);
    req_o = '{1'b1, c, d};
    @(negedge ref_clk_i);
    req_o = '0;
    got = rsp_i;
  endtask : send
  // force, then read the control register back for the caller to check
  task automatic force_bgnd;
    send(CMD_FORCE_BGND, 16'h0000);
    send(CMD_READ_CTRL, 16'h0000);
  endtask : force_bgnd
endmodule : bdsc_host

//--- bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import bdsc_pkg::*;
  logic      ref_clk_i = 1'b0;
  logic      rstn_i    = 1'b0;
  logic      ce_i      = 1'b1;
  bdsc_req_t req;
  bdsc_cpu_t cpu       = '0;
  bdsc_rsp_t rsp;
  logic      enter, software_interrupt_instr, clk_sel, act;
  logic [15:0] m;
  logic [7:0]  w;
  logic [1:0]  s2;
  logic [7:0]  tab [3] = '{8'hB0, 8'hA0, 8'h90};
  int n_errors  = 0;
  int tests_run = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  bdsc_top dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .req_i(req), .cpu_i(cpu),
    .rsp_o(rsp), .enter_bgnd_o(enter), .swi_req_o(software_interrupt_instr), .comm_clk_sel_o(clk_sel),
    .bgnd_active_o(act));
  bdsc_host host (.ref_clk_i(ref_clk_i), .req_o(req), .rsp_i(rsp));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic end_of_test;
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  function automatic logic [15:0] ectl(input logic [7:0] v, input logic a, s, f);
    return {8'h00, v[7], a, v[5:3], s, f, 1'b0};
  endfunction : ectl
  // present a match as a bus-cycle boundary or a fetch then queue end
  task automatic brk(input logic tag, input logic [1:0] e);
    s2 = 2'b00;
    @(negedge ref_clk_i);
    cpu.addr = m;
    cpu.fetch = tag;
    cpu.boundary = !tag;
    @(negedge ref_clk_i);
    cpu = '0;
    cpu.queue_end = tag;
    s2 = {software_interrupt_instr, enter};
    @(negedge ref_clk_i);
    s2 |= {software_interrupt_instr, enter};
    cpu = '0;
    repeat (3) @(negedge ref_clk_i) s2 |= {software_interrupt_instr, enter};
    chk({14'h0000, s2}, {14'h0000, e});
  endtask : brk
  initial begin
    void'($urandom(49));
    repeat (10) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    chk({15'h0000, clk_sel}, 16'h0000);
    host.send(CMD_READ_CTRL, 16'h0000);
    chk(host.got.data, 16'h0000);
    chk({15'h0000, host.got.done}, 16'h0001);
    host.send(CMD_FORCE_BGND, 16'h0000);
    chk({15'h0000, host.got.fail}, 16'h0001);
    w = 8'($urandom) | 8'h80;
    host.send(CMD_WRITE_CTRL, {8'h00, w});
    chk({15'h0000, clk_sel}, {15'h0000, w[3]});
    host.send(CMD_READ_CTRL, 16'h0000);
    chk(host.got.data, ectl(w, 1'b0, 1'b0, 1'b0));
    cpu.wait_stop = 1'b1;
    host.send(CMD_MEM_ACCESS, 16'h0000);
    chk({15'h0000, host.got.fail}, 16'h0001);
    host.force_bgnd();
    chk(host.got.data, ectl(w, 1'b1, 1'b1, 1'b1));
    chk({15'h0000, act}, 16'h0001);
    cpu.wait_stop = 1'b0;
    host.send(CMD_MEM_ACCESS, 16'h0000);
    chk({15'h0000, host.got.fail}, 16'h0000);
    host.send(CMD_WRITE_CTRL, 16'h0000);
    host.send(CMD_READ_CTRL, 16'h0000);
    chk(host.got.data, ectl(8'h80, 1'b1, 1'b1, 1'b0));
    m = 16'($urandom) | 16'h0001;
    host.send(CMD_MATCH_WR, m);
    host.send(CMD_MATCH_RD, 16'h0000);
    chk(host.got.data, m);
    ce_i = 1'b0;
    host.send(CMD_WRITE_CTRL, 16'h0008);
    ce_i = 1'b1;
    chk({15'h0000, clk_sel}, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      host.send(CMD_WRITE_CTRL, {8'h00, tab[i]});
      host.send(CMD_GO, 16'h0000);
      chk({15'h0000, act}, 16'h0000);
      brk(!tab[i][4], {1'b0, tab[i][5]});
    end
    rstn_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    host.send(CMD_READ_CTRL, 16'h0000);
    chk(host.got.data, 16'h0000);
    host.send(CMD_MATCH_WR, m);
    host.send(CMD_WRITE_CTRL, 16'h0030);
    brk(1'b0, 2'b10);
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    n_errors++;
    end_of_test();
  end
endmodule : testbench
